// ==== logic/tosp_pkg.sv ====
// constants and carrier types of the two-channel one-shot pulse generator
// assumes a single 20 MHz clock domain and a classic wishbone register port
// Functional notes
// - two channels, period 256 prescaled clocks
// - falling trigger edge gives exactly one pulse
// - trigger source chosen by software
// - output polarity fixed per channel build option
// - preload zero gives full 256 periods
// - prescaler, 8-bit counter, 8-bit preload
// - count from preload, stop on rollover
// - overflow clears the software trigger bit
// - ch0 control bits 2-4 pick prescale
// - ch1 output replaces port pin when selected
// - stop clears prescaler, reloads, output inactive
// - synchronised start adds one clock through the arm state
// - prescaler steps on first edge type
// - ch0 control bits 0,1 enable comparators
// - comparator a pin 2 loses driver, pins 0-2 lose pull-ups
// - comparator b pin 3 loses driver, pins 3-4 lose pull-ups
// - disabled comparator leaves pins as gpio
// - ch0 bit5 enables irq b stop path (comparator a when exchange set)
// - ch0 bit6 enables comparator restart path
// - bit7 write one restarts, zero stops
// - select codes map to divisors ascending
// - polarity zero active high, one low
// - retriggers ignored while counting
package tosp_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CH0_CTRL_OFS = 8'h20;
  localparam logic [7:0] CH1_CTRL_OFS = 8'h22;
  localparam logic [7:0] CH0_PRE_OFS  = 8'h24;
  localparam logic [7:0] CH1_PRE_OFS  = 8'h28;
  localparam logic [7:0] STATUS_OFS   = 8'h2c;
  localparam logic [7:0] CTRL_RST     = 8'h00;
  localparam logic [7:0] PRE_RST      = 8'h00;

  // ----------------------------------------------------------------
  // control field positions
  // ----------------------------------------------------------------
  localparam int CMPA_EN_BIT  = 0;
  localparam int CMPB_EN_BIT  = 1;
  localparam int XCHG_BIT     = 0;
  localparam int PSC_LSB      = 2;
  localparam int STOP_EN_BIT  = 5;
  localparam int RSTRT_EN_BIT = 6;
  localparam int SOFT_BIT     = 7;
  localparam logic [7:0] CNT_TOP = 8'hff;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {TOSP_IDLE, TOSP_ARM, TOSP_RUN} tosp_state_t;

  typedef struct packed {
    tosp_state_t st;
    logic        edge_fall;
    logic [6:0]  psc;
    logic [7:0]  cnt;
    logic        out_act;
  } tosp_chan_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } tosp_wb_req_t;

endpackage : tosp_pkg

// ==== logic/tosp_top.sv ====
// one-shot pulse generator, two channels, with comparator pin control
// assumes synchronous inputs on CLK and a classic wishbone master
`timescale 1ns/1ps
module tosp_top
  import tosp_pkg::*;
#(
  parameter bit CH0_POL_LOW = 1'b0,
  parameter bit CH1_POL_LOW = 1'b0,
  parameter bit CH1_ON_PIN  = 1'b1,
  parameter bit START_SYNC  = 1'b1
) (
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        COMPARATOR_A_OUT,
  input  wire logic        COMPARATOR_B_OUT,
  input  wire logic        EXT_IRQ_A,
  input  wire logic        EXT_IRQ_B,
  input  wire logic        PORT_A_BIT0_GPIO_O,
  input  wire logic        PORT_A_BIT0_GPIO_OE,
  input  wire logic [4:0]  PORT_C_GPIO_OE,
  input  wire logic [4:0]  PORT_C_PULLUP_REQ,
  output logic             PULSE_OUTPUT_0,
  output logic             PORT_A_BIT0_O,
  output logic             PORT_A_BIT0_OE,
  output logic [4:0]       PORT_C_OE_MASK,
  output logic [4:0]       PORT_C_PULLUP_EN
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]  rst_sync;
    logic [3:0]  trg_s1;
    logic [3:0]  trg_s2;
    logic [3:0]  trg_s3;
    logic [7:0]  ctrl0;
    logic [7:0]  ctrl1;
    logic [7:0]  pre0;
    logic [7:0]  pre1;
    tosp_chan_t  ch0;
    tosp_chan_t  ch1;
    logic        ack;
    logic [31:0] rdat;
    logic        pout0;
    logic        pa_o;
    logic        pa_oe;
    logic [4:0]  pc_oe;
    logic [4:0]  pc_pu;
  } tosp_regs_t;

  tosp_regs_t   q;
  tosp_regs_t   d;
  logic         rst_n;
  logic [3:0]   trg_fall;
  logic         half_fall;
  tosp_wb_req_t req;

  assign rst_n = q.rst_sync[1];
  assign req   = '{cyc: WB_CYC_I, stb: WB_STB_I, we: WB_WE_I, adr: WB_ADR_I,
                   sel: WB_SEL_I, dat: WB_DAT_I};

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [6:0] psc_mask(input logic [2:0] sel);
    psc_mask = 7'((8'h01 << sel) - 8'h01);
  endfunction : psc_mask

  // one channel step: start, stop, prescaled count
  function automatic tosp_chan_t chan_step(
    input tosp_chan_t c,
    input logic [2:0] psel,
    input logic [7:0] pre,
    input logic       start,
    input logic       stop,
    input logic       half
  );
    tosp_chan_t n;
    logic       tick;
    n    = c;
    tick = 1'b0;
    case (c.st)
      TOSP_IDLE: begin
        n.cnt = pre;
        if (start && !stop) begin
          n.st = START_SYNC ? TOSP_ARM : TOSP_RUN;
          n.out_act   = !START_SYNC;
          n.psc       = '0;
          n.edge_fall = 1'b0;
        end
      end
      TOSP_ARM: begin
        n.st        = TOSP_RUN;
        n.out_act   = 1'b1;
        n.edge_fall = half;
      end
      TOSP_RUN: begin
        if (n.psc == psc_mask(psel)) begin
          tick  = 1'b1;
          n.psc = '0;
        end else begin
          n.psc = 7'(n.psc + 7'h01);
        end
        if (tick) begin
          n.cnt = 8'(c.cnt + 8'h01);
        end
      end
      default: n.st = TOSP_IDLE;
    endcase
    if (stop || (tick && c.cnt == CNT_TOP)) begin
      n.st      = TOSP_IDLE;
      n.psc     = '0;
      n.cnt     = pre;
      n.out_act = 1'b0;
    end
    chan_step = n;
  endfunction : chan_step

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic       hit;
    logic       wr;
    logic       run0;
    logic       run1;
    logic       sw0_set;
    logic       sw0_clr;
    logic       sw1_set;
    logic       sw1_clr;
    logic       stop0_hw;
    logic       start0_hw;
    logic       stop1_hw;
    logic       start1_hw;
    logic       trg_stop_sel;
    logic       trg_rstrt_sel;
    logic [7:0] wbyte;
    tosp_chan_t n0;
    tosp_chan_t n1;
    hit = 1'b0; wr = 1'b0; run0 = 1'b0; run1 = 1'b0;
    sw0_set = 1'b0; sw0_clr = 1'b0; sw1_set = 1'b0; sw1_clr = 1'b0;
    stop0_hw = 1'b0; start0_hw = 1'b0; stop1_hw = 1'b0; start1_hw = 1'b0;
    trg_stop_sel = 1'b0; trg_rstrt_sel = 1'b0;
    wbyte = 8'h00;
    n0 = q.ch0;
    n1 = q.ch1;
    d  = q;
    d.rst_sync = {q.rst_sync[0], 1'b1};
    // synchronisers: cmp a, cmp b, irq a, irq b
    d.trg_s1 = {EXT_IRQ_B, EXT_IRQ_A, COMPARATOR_B_OUT, COMPARATOR_A_OUT};
    d.trg_s2 = q.trg_s1;
    d.trg_s3 = q.trg_s2;
    trg_fall = q.trg_s3 & ~q.trg_s2;

    // bus slave
    hit   = req.cyc && req.stb && !q.ack;
    wr    = hit && req.we && req.sel[0];
    wbyte = req.dat[7:0];
    d.ack = hit;
    d.rdat = 32'h0;
    if (hit && !req.we) begin
      case (req.adr)
        CH0_CTRL_OFS: d.rdat = {24'h0, q.ctrl0};
        CH1_CTRL_OFS: d.rdat = {24'h0, q.ctrl1};
        CH0_PRE_OFS:  d.rdat = {24'h0, q.pre0};
        CH1_PRE_OFS:  d.rdat = {24'h0, q.pre1};
        STATUS_OFS:   d.rdat = {30'h0, q.ch1.st != TOSP_IDLE, q.ch0.st != TOSP_IDLE};
        default:      d.rdat = 32'h0;
      endcase
    end

    run0 = q.ch0.st != TOSP_IDLE;
    run1 = q.ch1.st != TOSP_IDLE;
    if (wr && req.adr == CH0_CTRL_OFS) begin
      sw0_set = wbyte[SOFT_BIT] && !q.ctrl0[SOFT_BIT];
      sw0_clr = !wbyte[SOFT_BIT] && q.ctrl0[SOFT_BIT];
      d.ctrl0 = wbyte;
    end
    if (wr && req.adr == CH1_CTRL_OFS) begin
      sw1_set = wbyte[SOFT_BIT] && !q.ctrl1[SOFT_BIT];
      sw1_clr = !wbyte[SOFT_BIT] && q.ctrl1[SOFT_BIT];
      d.ctrl1 = {wbyte[7:2], 1'b0, wbyte[XCHG_BIT]};
    end
    if (wr && req.adr == CH0_PRE_OFS) d.pre0 = wbyte;
    if (wr && req.adr == CH1_PRE_OFS) d.pre1 = wbyte;

    // trigger routing, exchange bit swaps cmp a and irq b
    trg_stop_sel  = q.ctrl1[XCHG_BIT] ? trg_fall[0] : trg_fall[3];
    trg_rstrt_sel = q.ctrl1[XCHG_BIT] ? trg_fall[3] : trg_fall[0];
    stop0_hw  = q.ctrl0[STOP_EN_BIT] && trg_stop_sel;
    start0_hw = q.ctrl0[RSTRT_EN_BIT] && trg_fall[1];
    stop1_hw  = q.ctrl1[STOP_EN_BIT] && trg_fall[2];
    start1_hw = q.ctrl1[RSTRT_EN_BIT] && trg_rstrt_sel;

    // running channel ignores further starts
    n0 = chan_step(q.ch0, q.ctrl0[PSC_LSB +: 3], q.pre0,
                   !run0 && (start0_hw || sw0_set), run0 && (stop0_hw || sw0_clr),
                   half_fall);
    n1 = chan_step(q.ch1, q.ctrl1[PSC_LSB +: 3], q.pre1,
                   !run1 && (start1_hw || sw1_set), run1 && (stop1_hw || sw1_clr),
                   half_fall);
    d.ch0 = n0;
    d.ch1 = n1;
    // trigger bit mirrors activity; hw start sets, any stop clears
    d.ctrl0[SOFT_BIT] = n0.st != TOSP_IDLE;
    d.ctrl1[SOFT_BIT] = n1.st != TOSP_IDLE;

    // outputs and pin sharing
    d.pout0 = n0.out_act ^ CH0_POL_LOW;
    d.pa_o  = CH1_ON_PIN ? (n1.out_act ^ CH1_POL_LOW) : PORT_A_BIT0_GPIO_O;
    d.pa_oe = CH1_ON_PIN ? 1'b1 : PORT_A_BIT0_GPIO_OE;
    d.pc_oe = PORT_C_GPIO_OE;
    d.pc_pu = PORT_C_PULLUP_REQ;
    if (d.ctrl0[CMPA_EN_BIT]) begin
      d.pc_oe[2]   = 1'b0;
      d.pc_pu[2:0] = 3'h0;
    end
    if (d.ctrl0[CMPB_EN_BIT]) begin
      d.pc_oe[3]   = 1'b0;
      d.pc_pu[4:3] = 2'h0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      q <= '{ctrl0: CTRL_RST, ctrl1: CTRL_RST, pre0: PRE_RST, pre1: PRE_RST,
             pout0: CH0_POL_LOW, pa_o: CH1_POL_LOW, default: '0};
    end else if (!rst_n) begin
      q          <= '{ctrl0: CTRL_RST, ctrl1: CTRL_RST, pre0: PRE_RST, pre1: PRE_RST,
                      pout0: CH0_POL_LOW, pa_o: CH1_POL_LOW, default: '0};
      q.rst_sync <= d.rst_sync;
    end else begin
      q <= d;
    end
  end

  // first edge type taken as rising in this single-edge build
  assign half_fall = 1'b0;

  assign WB_DAT_O         = q.rdat;
  assign WB_ACK_O         = q.ack;
  assign PULSE_OUTPUT_0   = q.pout0;
  assign PORT_A_BIT0_O    = q.pa_o;
  assign PORT_A_BIT0_OE   = q.pa_oe;
  assign PORT_C_OE_MASK   = q.pc_oe;
  assign PORT_C_PULLUP_EN = q.pc_pu;

endmodule : tosp_top

// ==== verif/tosp_load.sv ====
// load model on one pulse output: width and count of pulses
// assumes an active-high pulse sampled on the system clock
`timescale 1ns/1ps
module tosp_load (
  input  wire logic        clk,
  input  wire logic        pulse,
  output logic      [15:0] width,
  output logic      [7:0]  count
);
  logic [15:0] run = 16'h0;
  initial width = 16'h0;
  initial count = 8'h0;
  always @(posedge clk) begin
    if (pulse === 1'b1) begin
      run <= run + 16'h1;
    end else if (run != 16'h0) begin
      width <= run;
      count <= count + 8'h1;
      run   <= 16'h0;
    end
  end
endmodule : tosp_load

// ==== verif/tosp_monitor.sv ====
// assertions on the pulse generator ports
// assumes binding into tosp_top with default polarity
`timescale 1ns/1ps
module tosp_monitor
  import tosp_pkg::*;
#(parameter bit CH1_ON_PIN = 1'b1) (
  input wire logic        CLK,
  input wire logic        RESETN,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic        WB_ACK_O,
  input wire logic [4:0]  PORT_C_GPIO_OE,
  input wire logic [4:0]  PORT_C_PULLUP_REQ,
  input wire logic        PULSE_OUTPUT_0,
  input wire logic        PORT_A_BIT0_OE,
  input wire logic [4:0]  PORT_C_OE_MASK,
  input wire logic [4:0]  PORT_C_PULLUP_EN
);
  logic [2:0] age_q;
  logic [1:0] cmp_q;
  logic [1:0] cmp_d1_q;
  logic       wr0;
  assign wr0 = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && WB_SEL_I[0]
               && WB_ADR_I == CH0_CTRL_OFS;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      age_q    <= 3'h0;
      cmp_q    <= 2'h0;
      cmp_d1_q <= 2'h0;
    end else begin
      age_q    <= (age_q == 3'h7) ? age_q : age_q + 3'h1;
      cmp_q    <= wr0 ? WB_DAT_I[1:0] : cmp_q;
      cmp_d1_q <= cmp_q;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN || age_q != 3'h7);
  // ----------------------------------------------------------------
  // pins and pulse
  // ----------------------------------------------------------------
  a_cmpa_drv_off: assert property (cmp_q[0] && cmp_d1_q[0] |-> !PORT_C_OE_MASK[2])
    else $error("comparator a output pin still driven");
  a_cmpa_pull_off: assert property (cmp_q[0] && cmp_d1_q[0] |-> PORT_C_PULLUP_EN[2:0] == 3'h0)
    else $error("comparator a pull-ups still on");
  a_inputs_keep_io: assert property (PORT_C_OE_MASK[1:0] == $past(PORT_C_GPIO_OE[1:0])
    && PORT_C_OE_MASK[4] == $past(PORT_C_GPIO_OE[4])) else $error("input pin lost io");
  a_cmpb_pins_off: assert property (cmp_q[1] && cmp_d1_q[1]
    |-> !PORT_C_OE_MASK[3] && PORT_C_PULLUP_EN[4:3] == 2'h0) else $error("comparator b pins");
  a_gpio_a_pass: assert property (!cmp_q[0] && !cmp_d1_q[0]
    |-> PORT_C_OE_MASK[2] == $past(PORT_C_GPIO_OE[2])
    && PORT_C_PULLUP_EN[2:0] == $past(PORT_C_PULLUP_REQ[2:0])) else $error("port c gpio a");
  a_gpio_b_pass: assert property (!cmp_q[1] && !cmp_d1_q[1]
    |-> PORT_C_OE_MASK[3] == $past(PORT_C_GPIO_OE[3])
    && PORT_C_PULLUP_EN[4:3] == $past(PORT_C_PULLUP_REQ[4:3])) else $error("port c gpio b");
  a_soft_start: assert property (wr0 && WB_DAT_I[SOFT_BIT] |-> ##[1:3] PULSE_OUTPUT_0)
    else $error("software start gave no pulse");
  a_soft_stop: assert property (wr0 && !WB_DAT_I[SOFT_BIT] |-> ##[1:3] !PULSE_OUTPUT_0)
    else $error("software stop left pulse active");
  a_pin_pulse_drv: assert property (CH1_ON_PIN |-> PORT_A_BIT0_OE)
    else $error("shared pin not driven by pulse");
  c_start: cover property (wr0 && WB_DAT_I[SOFT_BIT]);
  c_both_cmp: cover property (cmp_q == 2'h3);
  c_pulse_end: cover property ($fell(PULSE_OUTPUT_0));
endmodule : tosp_monitor
bind tosp_top tosp_monitor #(.CH1_ON_PIN(CH1_ON_PIN)) i_tosp_monitor (
  .CLK(CLK), .RESETN(RESETN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
  .WB_ACK_O(WB_ACK_O), .PORT_C_GPIO_OE(PORT_C_GPIO_OE), .PORT_C_PULLUP_REQ(PORT_C_PULLUP_REQ),
  .PULSE_OUTPUT_0(PULSE_OUTPUT_0), .PORT_A_BIT0_OE(PORT_A_BIT0_OE),
  .PORT_C_OE_MASK(PORT_C_OE_MASK), .PORT_C_PULLUP_EN(PORT_C_PULLUP_EN));

// ==== verif/tb_tosp_top.sv ====
// bench for tosp_top: wishbone tasks, pulse widths, pin overrides
// assumes tosp_load models watching both pulse outputs
`timescale 1ns/1ps
module tb_tosp_top import tosp_pkg::*; ();
  logic        CLK, RESETN, cyc, stb, we, cmpa, cmpb, irqa, irqb, p0, p1, ack;
  logic [7:0]  adr, cnt0, cnt1;
  logic [31:0] wdat, rdat;
  logic [4:0]  oem, pue;
  logic [15:0] wid0, wid1;
  logic [4:0]  oe_tab [4] = '{5'h1f, 5'h1b, 5'h17, 5'h13};
  logic [4:0]  pu_tab [4] = '{5'h1f, 5'h18, 5'h07, 5'h00};
  int          fail_count = 0;
  int          compares = 0;
  tosp_top i_tosp_top (
    .CLK(CLK), .RESETN(RESETN), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .COMPARATOR_A_OUT(cmpa), .COMPARATOR_B_OUT(cmpb), .EXT_IRQ_A(irqa), .EXT_IRQ_B(irqb),
    .PORT_A_BIT0_GPIO_O(1'b0), .PORT_A_BIT0_GPIO_OE(1'b0), .PORT_C_GPIO_OE(5'h1f),
    .PORT_C_PULLUP_REQ(5'h1f), .PULSE_OUTPUT_0(p0), .PORT_A_BIT0_O(p1),
    .PORT_A_BIT0_OE(), .PORT_C_OE_MASK(oem), .PORT_C_PULLUP_EN(pue));
  tosp_load i_tosp_load_0 (.clk(CLK), .pulse(p0), .width(wid0), .count(cnt0));
  tosp_load i_tosp_load_1 (.clk(CLK), .pulse(p1), .width(wid1), .count(cnt1));
  always #25 CLK = ~CLK;
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(inout int n);
    @(posedge CLK);
    n++;
    if (n > 20000) begin
      fail_count++;
      $display("CHECK FAILED at %0t: wait timed out", $time);
      print_verdict();
    end
  endtask : tick
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    int n;
    n = 0;
    @(posedge CLK);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h0, d};
    do tick(n); while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk({8'h0, q}, {8'h0, e});
  endtask : rd
  task automatic wait_pulse(input bit ch);
    logic [7:0] c;
    int n;
    c = ch ? cnt1 : cnt0;
    n = 0;
    while ((ch ? cnt1 : cnt0) === c) tick(n);
  endtask : wait_pulse
  initial begin
    logic [7:0] c;
    CLK = 1'b0;
    RESETN = 1'b0;
    {cyc, stb, we, adr, wdat} = '0;
    cmpa = 1'b1;
    cmpb = 1'b1;
    irqa = 1'b1;
    irqb = 1'b1;
    repeat (2) @(posedge CLK);
    RESETN <= 1'b1;
    repeat (3) @(posedge CLK);
    rd(CH0_CTRL_OFS, CTRL_RST);
    rd(CH0_PRE_OFS, PRE_RST);
    wr(8'h30, 8'h55);
    rd(8'h30, 8'h00);
    $display("test done: reset and unmapped");
    for (int i = 0; i < 8; i++) begin
      wr(CH0_PRE_OFS, 8'hfc);
      wr(CH0_CTRL_OFS, 8'h80 | 8'(i << 2));
      wait_pulse(1'b0);
      chk(wid0, 16'h4 << i);
      rd(CH0_CTRL_OFS, 8'(i << 2));
    end
    wr(CH0_PRE_OFS, 8'h00);
    wr(CH0_CTRL_OFS, 8'h80);
    wait_pulse(1'b0);
    chk(wid0, 16'h100);
    wr(CH0_PRE_OFS, 8'hf0);
    wr(CH0_CTRL_OFS, 8'h80);
    wr(CH0_CTRL_OFS, 8'h80);
    wait_pulse(1'b0);
    chk(wid0, 16'h10);
    wr(CH0_PRE_OFS, 8'h00);
    wr(CH0_CTRL_OFS, 8'h8c);
    wr(CH0_CTRL_OFS, 8'h0c);
    rd(STATUS_OFS, 8'h00);
    chk({15'h0, p0}, 16'h0);
    $display("test done: software pulses");
    wr(CH0_PRE_OFS, 8'hfe);
    wr(CH0_CTRL_OFS, 8'h40);
    cmpb <= 1'b0;
    wait_pulse(1'b0);
    chk(wid0, 16'h2);
    c = cnt0;
    repeat (20) @(posedge CLK);
    chk({8'h0, cnt0}, {8'h0, c});
    wr(CH0_CTRL_OFS, 8'h00);
    cmpb <= 1'b1;
    repeat (5) @(posedge CLK);
    cmpb <= 1'b0;
    repeat (20) @(posedge CLK);
    chk({8'h0, cnt0}, {8'h0, c});
    wr(CH0_PRE_OFS, 8'h00);
    wr(CH0_CTRL_OFS, 8'ha0);
    repeat (10) @(posedge CLK);
    irqb <= 1'b0;
    wait_pulse(1'b0);
    chk({15'h0, wid0 < 16'h40}, 16'h1);
    rd(CH0_CTRL_OFS, 8'h20);
    wr(CH1_PRE_OFS, 8'hfe);
    wr(CH1_CTRL_OFS, 8'h80);
    wait_pulse(1'b1);
    chk(wid1, 16'h2);
    wr(CH1_PRE_OFS, 8'h00);
    wr(CH1_CTRL_OFS, 8'h60);
    cmpa <= 1'b0;
    repeat (10) @(posedge CLK);
    rd(STATUS_OFS, 8'h02);
    rd(CH1_CTRL_OFS, 8'he0);
    irqa <= 1'b0;
    wait_pulse(1'b1);
    chk({15'h0, wid1 < 16'h40}, 16'h1);
    rd(CH1_CTRL_OFS, 8'h60);
    wr(CH1_CTRL_OFS, 8'h01);
    wr(CH1_CTRL_OFS, 8'h41);
    irqb <= 1'b1;
    repeat (5) @(posedge CLK);
    irqb <= 1'b0;
    wait_pulse(1'b1);
    chk(wid1, 16'h100);
    $display("test done: triggers and channel 1");
    for (int i = 0; i < 4; i++) begin
      wr(CH0_CTRL_OFS, 8'(i));
      repeat (3) @(posedge CLK);
      chk({11'h0, oem}, {11'h0, oe_tab[i]});
      chk({11'h0, pue}, {11'h0, pu_tab[i]});
    end
    $display("test done: comparator pins");
    print_verdict();
  end
endmodule : tb_tosp_top
